/* core/ptag_if.sv */
// primary tag copy port between capture logic and its storage
`timescale 1ns/1ps
interface ptag_if #(parameter int ADDR_W = 8, parameter int DATA_W = 20);
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

/* core/ptag_mem.sv */
// primary tag store copy storage with registered read data
`timescale 1ns/1ps
module ptag_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 20
)(
  input  wire logic mclk,
  ptag_if.mem       port
);
  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_q;

  always_ff @(posedge mclk)
  begin
    if (port.we)
    begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule

/* core/tag_capture_pkg.sv */
// types shared by the tag status capture block
package tag_capture_pkg;
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_MEM_READ,
    CYC_MEM_WRITE,
    CYC_DMA_FILL,
    CYC_DMA_WRITE,
    CYC_IBUS,
    CYC_EPR
  } cycle_kind_t;
  typedef logic [3:0] bus_cmd_t;
  typedef struct packed {
    logic p2_hit;
    logic p1_hit;
    logic backup_store_hit;
    logic bts_match;
    logic p2_perr;
    logic p1_perr;
    logic bts_perr;
  } tag_result_t;
endpackage

/* core/tag_capture_regs.svh */
// register offsets, field positions and reset values of the tag status capture block
`ifndef TAG_CAPTURE_REGS_SVH
`define TAG_CAPTURE_REGS_SVH
`define TSC_ADDR_W          8
`define TSC_OFF_STATUS      8'h76
`define TSC_OFF_INDEX       8'h75
`define TSC_OFF_PBANK_ONE   8'h72
`define TSC_OFF_PBANK_TWO   8'h73
`define TSC_STS_LOCK        0
`define TSC_STS_BTS_PERR    1
`define TSC_STS_P1_PERR     2
`define TSC_STS_P2_PERR     3
`define TSC_STS_BUS_ERR     4
`define TSC_STS_BTS_MATCH   17
`define TSC_STS_BACKUP_STORE_HIT     18
`define TSC_STS_P1_HIT      19
`define TSC_STS_P2_HIT      20
`define TSC_STS_CMD_LO      21
`define TSC_STS_CMD_HI      24
`define TSC_STS_IBUS        25
`define TSC_STS_PRED_PAR    26
`define TSC_IDX_COL_LO      9
`define TSC_IDX_COL_HI      10
`define TSC_IDX_ROW_LO      4
`define TSC_IDX_ROW_HI      8
`define TSC_IDX_WR_MASK     32'h000007F0
`define TSC_STS_RESET       32'h00000000
`define TSC_IDX_RESET       32'h00000000
`define TSC_PT_TAG_LO       11
`define TSC_PT_TAG_HI       28
`define TSC_PT_PAR          29
`define TSC_PT_VALID        2
`endif

/* core/tag_store_status_capture.sv */
// status capture, lock and primary tag index view of the backup cache controller
`timescale 1ns/1ps
`include "tag_capture_regs.svh"

module tag_store_status_capture
  import tag_capture_pkg::*;
#(
  parameter int ROW_W = 5,
  parameter int COL_W = 2,
  parameter int TAG_W = 18
)(
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire tag_capture_pkg::cycle_kind_t cycle_kind,
  input  wire tag_capture_pkg::bus_cmd_t    bus_cmd,
  input  wire tag_capture_pkg::tag_result_t tag_result,
  input  wire logic                         pred_parity,
  input  wire logic                         bus_error,
  input  wire logic                         primary_store_enable,
  input  wire logic                         backup_store_enable,
  input  wire logic                         force_hit,
  input  wire logic                         reg_rd,
  input  wire logic                         reg_wr,
  input  wire logic [`TSC_ADDR_W-1:0]       reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  output logic      [31:0]                  reg_rdata,
  output logic                              reg_ack,
  output logic                              primary_store_active,
  output logic                              backup_store_active,
  output logic                              error_addr_load_en,
  output logic                              system_error_irq_n
);
  import tag_capture_pkg::*;

  localparam int PADDR_W = ROW_W + COL_W;
  localparam int PDATA_W = TAG_W + 2;

  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] index_q;
  logic [31:0] rdata_d;
  logic        rd_pend_q;

  ptag_if #(.ADDR_W(PADDR_W + 1), .DATA_W(PDATA_W)) ptag ();

  ptag_mem #(.ADDR_W(PADDR_W + 1), .DATA_W(PDATA_W)) u_mem (
    .mclk (mclk),
    .port (ptag)
  );

  wire locked      = status_q[`TSC_STS_LOCK];
  wire is_mem      = (cycle_kind == CYC_MEM_READ) || (cycle_kind == CYC_MEM_WRITE);
  wire is_dma      = (cycle_kind == CYC_DMA_FILL) || (cycle_kind == CYC_DMA_WRITE);
  wire is_ibus     = (cycle_kind == CYC_IBUS);
  wire load_all    = (is_dma || is_ibus) && !locked;
  wire load_mem    = is_mem && backup_store_enable && !locked;
  wire load        = load_all || load_mem;
  wire p_ok        = primary_store_enable && load_all;
  wire b_ok        = backup_store_enable && !force_hit;
  wire p2_err      = p_ok && tag_result.p2_perr;
  wire p1_err      = p_ok && tag_result.p1_perr;
  wire bts_err     = load && b_ok && tag_result.bts_perr;
  wire berr_set    = bus_error && !locked && (is_mem || is_dma);
  wire any_set     = p2_err || p1_err || bts_err || berr_set;
  wire sel_sts     = reg_addr == `TSC_OFF_STATUS;
  wire sel_idx     = reg_addr == `TSC_OFF_INDEX;
  wire sel_p1      = reg_addr == `TSC_OFF_PBANK_ONE;
  wire sel_p2      = reg_addr == `TSC_OFF_PBANK_TWO;
  wire sel_pt      = sel_p1 || sel_p2;
  wire unlock      = reg_wr && sel_sts && reg_wdata[`TSC_STS_LOCK];
  wire [COL_W-1:0] pcol = index_q[`TSC_IDX_COL_HI:`TSC_IDX_COL_LO];
  wire [ROW_W-1:0] prow = index_q[`TSC_IDX_ROW_HI:`TSC_IDX_ROW_LO];
  wire [TAG_W-1:0] wtag = reg_wdata[`TSC_PT_TAG_HI:`TSC_PT_TAG_LO];
  wire             wpar = ~^wtag;
  wire [PDATA_W-1:0] rd_ent = ptag.rdata;

  assign ptag.addr  = {sel_p2, pcol, prow};
  assign ptag.we    = reg_wr && sel_pt;
  assign ptag.wdata = {wpar, wtag, reg_wdata[`TSC_PT_VALID]};

  always_comb
  begin
    status_d = status_q;
    // clear first; a fault in the unlock cycle sticks only if status was unlocked, since load and berr_set are gated by locked
    if (unlock)
    begin
      status_d[`TSC_STS_BUS_ERR:`TSC_STS_LOCK]     = 5'h00;
    end
    if (load)
    begin
      status_d[`TSC_STS_PRED_PAR]                  = pred_parity;
      status_d[`TSC_STS_IBUS]                      = is_ibus;
      status_d[`TSC_STS_CMD_HI:`TSC_STS_CMD_LO]    = bus_cmd;
      status_d[`TSC_STS_P2_HIT]                    = tag_result.p2_hit;
      status_d[`TSC_STS_P1_HIT]                    = tag_result.p1_hit;
      status_d[`TSC_STS_BACKUP_STORE_HIT]                   = tag_result.backup_store_hit;
      status_d[`TSC_STS_BTS_MATCH]                 = tag_result.bts_match;
      status_d[`TSC_STS_P2_PERR]                   = p2_err;
      status_d[`TSC_STS_P1_PERR]                   = p1_err;
      if (b_ok)
      begin
        status_d[`TSC_STS_BTS_PERR]                = tag_result.bts_perr;
      end
    end
    if (berr_set)
    begin
      status_d[`TSC_STS_BUS_ERR]                   = 1'b1;
    end
    if (any_set)
    begin
      status_d[`TSC_STS_LOCK]                      = 1'b1;
    end
    status_d[31:27] = 5'h00;
    status_d[16:5]  = 12'h000;
  end

  always_comb
  begin
    rdata_d = 32'h00000000;
    if (sel_sts)
    begin
      rdata_d = status_q;
    end
    else if (sel_idx)
    begin
      rdata_d = index_q;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      status_q <= `TSC_STS_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      index_q <= `TSC_IDX_RESET;
    end
    else if (reg_wr && sel_idx)
    begin
      index_q <= reg_wdata & `TSC_IDX_WR_MASK;
    end
  end

  // tag reads come from the memory's output register one cycle later
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata  <= 32'h00000000;
      reg_ack    <= 1'b0;
      rd_pend_q  <= 1'b0;
    end
    else
    begin
      rd_pend_q  <= reg_rd && sel_pt;
      reg_ack    <= rd_pend_q || reg_wr || (reg_rd && !sel_pt);
      if (rd_pend_q)
      begin
        reg_rdata <= {2'b00, rd_ent[PDATA_W-1], rd_ent[PDATA_W-2:1], 8'h00,
                      rd_ent[0], 2'b00};
      end
      else if (reg_rd && !sel_pt)
      begin
        reg_rdata <= rdata_d;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      primary_store_active <= 1'b0;
      backup_store_active  <= 1'b0;
      error_addr_load_en   <= 1'b0;
      system_error_irq_n   <= 1'b1;
    end
    else
    begin
      primary_store_active <= primary_store_enable && !status_d[`TSC_STS_LOCK];
      backup_store_active  <= backup_store_enable && !status_d[`TSC_STS_LOCK];
      error_addr_load_en   <= !status_d[`TSC_STS_LOCK];
      system_error_irq_n   <= !(p2_err || p1_err || bts_err);
    end
  end

  property p_lock_freezes;
    @(posedge mclk) disable iff (rst)
      (locked && !unlock) |=> (status_q == $past(status_q));
  endproperty
  a_lock_freezes: assert property (p_lock_freezes) else $error("locked status changed");

  property p_parity_locks;
    @(posedge mclk) disable iff (rst)
      (load_all && primary_store_enable && tag_result.p1_perr) |=> locked;
  endproperty
  a_parity_locks: assert property (p_parity_locks) else $error("parity fault did not lock");

  property p_unlock_clears;
    @(posedge mclk) disable iff (rst)
      (unlock && !any_set) |=> (status_q[4:0] == 5'h00);
  endproperty
  a_unlock_clears: assert property (p_unlock_clears) else $error("unlock left error flags");

  property p_mem_no_ptag_err;
    @(posedge mclk) disable iff (rst)
      (load_mem && !locked) |=> (status_q[3:2] == 2'b00);
  endproperty
  a_mem_no_ptag_err: assert property (p_mem_no_ptag_err) else $error("primary error on mem");

  property p_ibus_bit;
    @(posedge mclk) disable iff (rst)
      load |=> (status_q[`TSC_STS_IBUS] == $past(is_ibus));
  endproperty
  a_ibus_bit: assert property (p_ibus_bit) else $error("invalidate bit wrong");

  property p_pred_par;
    @(posedge mclk) disable iff (rst)
      load |=> (status_q[`TSC_STS_PRED_PAR] == $past(pred_parity));
  endproperty
  a_pred_par: assert property (p_pred_par) else $error("predicted parity not captured");

  property p_epr_no_load;
    @(posedge mclk) disable iff (rst)
      (cycle_kind == CYC_EPR && !unlock) |=> (status_q == $past(status_q));
  endproperty
  a_epr_no_load: assert property (p_epr_no_load) else $error("register cycle loaded status");

  property p_mbz;
    @(posedge mclk) disable iff (rst)
      (status_q[31:27] == 5'h00) && (status_q[16:5] == 12'h000) && (index_q[31:11] == 21'h0);
  endproperty
  a_mbz: assert property (p_mbz) else $error("reserved bit set");

  property p_lock_disables;
    @(posedge mclk) disable iff (rst)
      locked |-> (!primary_store_active && !backup_store_active);
  endproperty
  a_lock_disables: assert property (p_lock_disables) else $error("store active while locked");

  property p_bus_err_locks;
    @(posedge mclk) disable iff (rst)
      berr_set |=> (locked && status_q[`TSC_STS_BUS_ERR]);
  endproperty
  a_bus_err_locks: assert property (p_bus_err_locks) else $error("bus error lost");

  property p_hit_capture;
    @(posedge mclk) disable iff (rst)
      load |=> (status_q[`TSC_STS_P2_HIT:`TSC_STS_BTS_MATCH] == $past(tag_result[6:3]));
  endproperty
  a_hit_capture: assert property (p_hit_capture) else $error("hit fields wrong");

  property p_cmd_capture;
    @(posedge mclk) disable iff (rst)
      (load && !is_ibus) |=> (status_q[`TSC_STS_CMD_HI:`TSC_STS_CMD_LO] == $past(bus_cmd));
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("command field wrong");

  property p_bts_gate;
    @(posedge mclk) disable iff (rst)
      (load && !b_ok && !unlock) |=>
        (status_q[`TSC_STS_BTS_PERR] == $past(status_q[`TSC_STS_BTS_PERR]));
  endproperty
  a_bts_gate: assert property (p_bts_gate) else $error("gated backup fault loaded");

  property p_irq_on_fault;
    @(posedge mclk) disable iff (rst)
      (load_all && primary_store_enable && tag_result.p2_perr) |=> !system_error_irq_n;
  endproperty
  a_irq_on_fault: assert property (p_irq_on_fault) else $error("fault raised no irq");

  c_ibus_load:  cover property (@(posedge mclk) disable iff (rst) load_all && is_ibus);
  c_lock:       cover property (@(posedge mclk) disable iff (rst) !locked ##1 locked);
  c_unlock:     cover property (@(posedge mclk) disable iff (rst) locked ##1 unlock);
  c_mem_load:   cover property (@(posedge mclk) disable iff (rst) load_mem);
  c_bus_err:    cover property (@(posedge mclk) disable iff (rst) berr_set);
endmodule

/* verif/proc_core_model.sv */
// processor core side model issuing one-cycle register read and write strobes
`timescale 1ns/1ps
module proc_core_model (
  input  wire logic        mclk,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack,
  output logic             timed_out
);
  initial
  begin
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h00000000;
    timed_out = 1'b0;
  end

  // writing 1 to the lock position is how software unlocks the status register
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge mclk);
    reg_rd    = !wr;
    reg_wr    = wr;
    reg_addr  = a;
    reg_wdata = wd;
    @(negedge mclk);
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~wd;
    while (reg_ack !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    if (reg_ack !== 1'b1)
      timed_out = 1'b1;
    rd = reg_rdata;
  endtask
endmodule

/* verif/test_tag_store_status_capture.sv */
// self-checking bench of the tag status capture block
`timescale 1ns/1ps
`include "tag_capture_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_tag_store_status_capture;
  import tag_capture_pkg::*;
  logic mclk, rst, pred_parity, bus_error, pe, be, fh, reg_rd, reg_wr, reg_ack, tmo;
  logic p_act, b_act, ea_en, irq_n;
  cycle_kind_t cycle_kind;
  bus_cmd_t    bus_cmd;
  tag_result_t tag_result;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, exp_sts;
  logic [15:0] lf;
  int          failures, checks;
  logic [31:0] ent [4];

  tag_store_status_capture u_tag_store_status_capture (.mclk(mclk), .rst(rst),
    .cycle_kind(cycle_kind), .bus_cmd(bus_cmd), .tag_result(tag_result),
    .pred_parity(pred_parity), .bus_error(bus_error), .primary_store_enable(pe),
    .backup_store_enable(be), .force_hit(fh), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .primary_store_active(p_act), .backup_store_active(b_act),
    .error_addr_load_en(ea_en), .system_error_irq_n(irq_n));
  proc_core_model u_proc_core_model (.mclk(mclk), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .timed_out(tmo));

  function automatic logic [15:0] nx(logic [15:0] x);
    return x[0] ? ((x >> 1) ^ 16'hB400) : (x >> 1);
  endfunction

  function automatic logic [31:0] nxt(logic [31:0] s, cycle_kind_t k, bus_cmd_t c,
                                      tag_result_t t, logic p, logic b);
    logic        mem;
    logic        dma;
    logic [31:0] n;
    mem = (k == CYC_MEM_READ) || (k == CYC_MEM_WRITE);
    dma = (k == CYC_DMA_FILL) || (k == CYC_DMA_WRITE);
    n = s;
    if (s[0])
      return s;
    if ((mem && be) || dma || k == CYC_IBUS)
    begin
      n[26] = p;
      n[25] = (k == CYC_IBUS);
      if (k != CYC_IBUS)
        n[24:21] = c;
      n[20:17] = {t.p2_hit, t.p1_hit, t.backup_store_hit, t.bts_match};
      n[3:2] = (pe && !mem) ? {t.p2_perr, t.p1_perr} : 2'b00;
      n[1] = be && !fh && t.bts_perr;
    end
    // a bus error locks even on a memory cycle that loaded nothing
    n[4] = n[4] | (b && (mem || dma));
    n[0] = |n[4:1];
    return n;
  endfunction

  task automatic chk_sts();
    logic [31:0] m;
    m = exp_sts[25] ? 32'hFE1FFFFF : 32'hFFFFFFFF;
    u_proc_core_model.access(1'b0, `TSC_OFF_STATUS, 32'h00000000, rd);
    `CHK(rd & m, exp_sts & m)
    `CHK({p_act, b_act, ea_en}, {pe & !exp_sts[0], be & !exp_sts[0], !exp_sts[0]})
  endtask

  task automatic cyc(cycle_kind_t k, bus_cmd_t c, tag_result_t t, logic p, logic b);
    logic [31:0] n;
    n = nxt(exp_sts, k, c, t, p, b);
    @(negedge mclk);
    cycle_kind = k;
    bus_cmd = c;
    tag_result = t;
    pred_parity = p;
    bus_error = b;
    @(negedge mclk);
    cycle_kind = CYC_IDLE;
    bus_error = 1'b0;
    tag_result = '0;
    `CHK(irq_n, !(|n[3:1] && !exp_sts[0]))
    exp_sts = n;
    chk_sts();
  endtask

  task automatic unlock();
    u_proc_core_model.access(1'b1, `TSC_OFF_STATUS, 32'hFFFFFFFE, rd);
    chk_sts();
    u_proc_core_model.access(1'b1, `TSC_OFF_STATUS, 32'h00000001, rd);
    exp_sts = exp_sts & ~32'h0000001F;
    chk_sts();
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    rst = 1'b1;
    cycle_kind = CYC_IDLE;
    bus_cmd = 4'h0;
    tag_result = '0;
    pred_parity = 1'b0;
    bus_error = 1'b0;
    pe = 1'b1;
    be = 1'b1;
    fh = 1'b0;
    failures = 0;
    checks = 0;
    exp_sts = 32'h00000000;
    lf = 16'h721F;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    chk_sts();
    u_proc_core_model.access(1'b0, 8'h10, 32'h0, rd);
    `CHK(rd, 32'h00000000)
    u_proc_core_model.access(1'b1, `TSC_OFF_INDEX, 32'hFFFFFFFF, rd);
    u_proc_core_model.access(1'b0, `TSC_OFF_INDEX, 32'h0, rd);
    `CHK(rd, 32'h000007F0)
    for (int i = 0; i < 4; i++)
    begin
      lf = nx(lf);
      ent[i] = {4'h0, lf[15:0], ~lf[1], 8'h00, lf[2], 2'b00} ^ {2'b00, ~^{lf, ~lf[1]}, 29'h0};
      u_proc_core_model.access(1'b1, `TSC_OFF_INDEX, i[0] ? 32'h000007F0 : 32'h00000010, rd);
      u_proc_core_model.access(1'b1, i[1] ? `TSC_OFF_PBANK_TWO : `TSC_OFF_PBANK_ONE, ent[i], rd);
    end
    for (int i = 0; i < 4; i++)
    begin
      u_proc_core_model.access(1'b1, `TSC_OFF_INDEX, i[0] ? 32'h000007F0 : 32'h00000010, rd);
      u_proc_core_model.access(1'b0, i[1] ? `TSC_OFF_PBANK_TWO : `TSC_OFF_PBANK_ONE, 32'h0, rd);
      `CHK(rd, ent[i])
    end
    cyc(CYC_DMA_FILL, 4'hA, 7'b1010_010, 1'b1, 1'b0);
    cyc(CYC_DMA_WRITE, 4'h5, 7'b0101_000, 1'b0, 1'b0);
    unlock();
    cyc(CYC_MEM_READ, 4'h3, 7'b0011_000, 1'b1, 1'b1);
    unlock();
    for (int i = 0; i < 150; i++)
    begin
      lf = nx(lf);
      pe = lf[11];
      be = lf[12] | lf[13];
      fh = be & lf[14];
      cyc(cycle_kind_t'(3'(lf % 6) + 3'd1), lf[7:4],
          {lf[3:0], (lf[10:8] == 3'd0) ? lf[6:4] : 3'b000}, lf[15],
          (lf[15:13] == 3'd0));
      if (exp_sts[0])
        unlock();
    end
    `CHK(tmo, 1'b0)
    report_and_stop();
  end
endmodule
